// >>> src/sct_regs.svh
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

// Register offsets on the register port (6-bit address space)
`define SCT_ADDR_W 6
`define SCT_DATA_W 24
`define SCT_OFF_CLEAN_EN 6'h20
`define SCT_OFF_THRESH 6'h21
// Reset values
`define SCT_RST_CLEAN_EN 24'h00_0000
`define SCT_RST_THRESH 24'h00_0000
// Writable field mask of the threshold register, bits 11..0
`define SCT_THRESH_WMASK 24'h00_0FFF
// Threshold group selects: group g sits at bits 2g+1..2g
`define SCT_GROUPS 6
`define SCT_GROUP_INPUTS 4
`define SCT_INPUTS 24
// Threshold codes
`define SCT_THR_2V0 2'h0
`define SCT_THR_2V7 2'h1
`define SCT_THR_3V0 2'h2
`define SCT_THR_4V0 2'h3
// Cleaning pulse duration: 64 us per step, code 0 = 64 us
`define SCT_PULSE_STEP_US 64
`define SCT_CLK_MHZ 50
`define SCT_PULSE_STEP_CYC (`SCT_PULSE_STEP_US * `SCT_CLK_MHZ)
// Current level groups of six inputs
`define SCT_LEVEL_GROUPS 4
`define SCT_LEVEL_GROUP_INPUTS 6

`endif

// >>> src/sct_pkg.sv
package sct_pkg;
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [23:0] wdata;
    } sct_req_s;

    // Register port answer
    typedef struct packed {
        logic valid;
        logic [23:0] rdata;
    } sct_rsp_s;

    // Per-group threshold selects
    typedef logic [1:0] sct_thr_t;
endpackage

// >>> src/sct_thresh_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "sct_regs.svh"

// Fans the packed group codes of the threshold register out to each input
module sct_thresh_decode (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] thresh_fields,
    output var logic [47:0] input_thr_sel
);
    // Whole state in one struct
    typedef struct packed {
        logic [47:0] sel;
    } sct_dec_state_s;

    sct_dec_state_s st_q;
    sct_dec_state_s st_d;

    // Each input takes the two-bit code of its group of four
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < `SCT_INPUTS; i++) begin
            st_d.sel[2*i +: 2] = thresh_fields[2*(i/`SCT_GROUP_INPUTS) +: 2];
        end
    end

    // Registered so the analog side sees glitch-free selects
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign input_thr_sel = st_q.sel;
endmodule

`default_nettype wire

// >>> src/sct_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sct_regs.svh"

module sct_top (
    input wire logic clk,
    input wire logic srst,
    input wire sct_pkg::sct_req_s req,
    input wire logic [2:0] cleaning_pulse_duration,
    input wire logic [3:0] cleaning_current_level,
    input wire logic cleaning_pulse_fire,
    output var sct_pkg::sct_rsp_s rsp,
    output var logic [23:0] cleaning_enable_input,
    output var logic [23:0] cleaning_drive,
    output var logic [23:0] cleaning_level_15ma,
    output var logic [11:0] threshold_sel,
    output var logic [47:0] input_thr_sel
);
    // Whole state of the block
    typedef struct packed {
        logic [23:0] clean_en;
        logic [11:0] thresh;
        sct_pkg::sct_rsp_s rsp;
        logic [23:0] drive;
        logic [23:0] level;
        logic [15:0] cnt;
        logic [2:0] steps;
        logic [15:0] run; // Cycles of the latest pulse, kept after it ends
        logic [2:0] code; // Duration code the latest pulse started with
    } sct_state_s;

    sct_state_s st_q;
    sct_state_s st_d;

    // Read mux value for the addressed register
    logic [23:0] rd_val;

    // Length of one pulse step in cycles, the same for every duration code
    logic [15:0] pulse_cycles;

    // High while a cleaning pulse is being timed
    logic pulse_busy;

    // Returns the read image of a register; reserved bits come back zero
    always_comb begin
        case (req.addr)
            `SCT_OFF_CLEAN_EN: rd_val = st_q.clean_en;
            `SCT_OFF_THRESH: rd_val = {12'h000, st_q.thresh};
            default: rd_val = 24'h00_0000;
        endcase
    end

    // One step per code count; code 0 is one step of 64 us
    assign pulse_cycles = 16'(`SCT_PULSE_STEP_CYC);

    // Timer state that marks a running pulse
    assign pulse_busy = (st_q.cnt != 16'h0000) || (st_q.steps != 3'h0);

    // Next-state logic: register writes, read answer, cleaning pulse timer
    always_comb begin
        st_d = st_q;
        st_d.rsp.valid = req.rd;
        st_d.rsp.rdata = req.rd ? rd_val : 24'h00_0000;
        if (req.wr) begin
            case (req.addr)
                `SCT_OFF_CLEAN_EN: st_d.clean_en = req.wdata;
                // Only the low twelve bits exist; upper writes are dropped
                `SCT_OFF_THRESH: st_d.thresh = req.wdata[11:0];
                default: st_d.clean_en = st_q.clean_en;
            endcase
        end
        // Current level per group of six inputs, 1 means 15 mA
        for (int i = 0; i < `SCT_INPUTS; i++) begin
            st_d.level[i] = cleaning_current_level[i/`SCT_LEVEL_GROUP_INPUTS];
        end
        // Pulse timer: starts on fire, runs duration code + 1 steps
        if (st_q.cnt != 16'h0000) begin
            st_d.cnt = st_q.cnt - 16'h0001;
        end else if (st_q.steps != 3'h0) begin
            st_d.steps = st_q.steps - 3'h1;
            st_d.cnt = pulse_cycles - 16'h0001;
        end else if (cleaning_pulse_fire) begin
            st_d.steps = cleaning_pulse_duration;
            st_d.code = cleaning_pulse_duration;
            // First step loads the full count; reloads spend their zero cycle still busy
            st_d.cnt = pulse_cycles;
        end
        // Drive only inputs whose enable bit is set, only while timing
        if ((st_d.cnt != 16'h0000) || (st_d.steps != 3'h0)) begin
            st_d.drive = st_d.clean_en;
            // Length so far, left standing once the pulse ends so it can be checked
            st_d.run = pulse_busy ? (st_q.run + 16'h0001) : 16'h0001;
        end else begin
            st_d.drive = 24'h00_0000;
        end
    end

    // State register; reset clears everything to the lowest codes
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Per-input threshold selects for the comparators
    sct_thresh_decode u_dec (
        .clk(clk),
        .srst(srst),
        .thresh_fields(st_d.thresh),
        .input_thr_sel(input_thr_sel)
    );

    assign rsp = st_q.rsp;
    assign cleaning_enable_input = st_q.clean_en;
    assign cleaning_drive = st_q.drive;
    assign cleaning_level_15ma = st_q.level;
    assign threshold_sel = st_q.thresh;

    // Enable register follows a write one cycle later
    property p_clean_wr;
        @(posedge clk) disable iff (srst)
        req.wr && req.addr == `SCT_OFF_CLEAN_EN |=> cleaning_enable_input == $past(req.wdata);
    endproperty
    a_clean_wr: assert property (p_clean_wr) else $error("enable write lost");

    // Threshold write keeps only low twelve bits
    property p_thr_wr;
        @(posedge clk) disable iff (srst)
        req.wr && req.addr == `SCT_OFF_THRESH |=> threshold_sel == $past(req.wdata[11:0]);
    endproperty
    a_thr_wr: assert property (p_thr_wr) else $error("threshold write wrong");

    // Reserved upper bits always read zero
    property p_resv;
        @(posedge clk) disable iff (srst)
        req.rd && req.addr == `SCT_OFF_THRESH |=> rsp.valid && rsp.rdata[23:12] == 12'h000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero");

    // Read returns current enable contents
    property p_rd;
        @(posedge clk) disable iff (srst)
        req.rd && !req.wr && req.addr == `SCT_OFF_CLEAN_EN |=> rsp.rdata == cleaning_enable_input;
    endproperty
    a_rd: assert property (p_rd) else $error("read mismatch");

    // After reset both registers are zero
    property p_rst;
        @(posedge clk) $past(srst) |-> cleaning_enable_input == 24'h00_0000 && threshold_sel == 12'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");

    // No current on a disabled input
    property p_gate;
        @(posedge clk) disable iff (srst)
        (cleaning_drive & ~cleaning_enable_input) == 24'h00_0000;
    endproperty
    a_gate: assert property (p_gate) else $error("drive on disabled input");

    // Group 0 select stands at input 3 two cycles after a write
    property p_grp0;
        @(posedge clk) disable iff (srst)
        req.wr && req.addr == `SCT_OFF_THRESH ##1 !(req.wr && req.addr == `SCT_OFF_THRESH)
        |=> input_thr_sel[7:6] == threshold_sel[1:0];
    endproperty
    a_grp0: assert property (p_grp0) else $error("group 0 select wrong");

    // Level bit follows its six-input group
    property p_level;
        @(posedge clk) disable iff (srst)
        ##1 cleaning_level_15ma[23] == $past(cleaning_current_level[3]);
    endproperty
    a_level: assert property (p_level) else $error("level group wrong");

    // A finished pulse lasted its code + 1 steps, counted by the run field
    property p_pulse;
        @(posedge clk) disable iff (srst)
        $fell(pulse_busy) |-> st_q.run == (st_q.code + 16'h0001) * pulse_cycles;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");

    // Threshold read returns the stored fields with a zero upper part
    property p_rd_thr;
        @(posedge clk) disable iff (srst)
        req.rd && !req.wr && req.addr == `SCT_OFF_THRESH |=> rsp.rdata == {12'h000, threshold_sel};
    endproperty
    a_rd_thr: assert property (p_rd_thr) else $error("threshold read mismatch");

    // Answer strobe stands exactly in the cycle after each read
    property p_valid;
        @(posedge clk) disable iff (srst)
        rsp.valid == $past(req.rd);
    endproperty
    a_valid: assert property (p_valid) else $error("answer strobe misplaced");

    // A write to any other offset leaves both registers alone
    property p_unmapped;
        @(posedge clk) disable iff (srst)
        req.wr && req.addr != `SCT_OFF_CLEAN_EN && req.addr != `SCT_OFF_THRESH
        |=> $stable(cleaning_enable_input) && $stable(threshold_sel);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("stray write stored");

    // Top and second group codes reach their inputs
    property p_grp_map;
        @(posedge clk) disable iff (srst)
        input_thr_sel[47:46] == threshold_sel[11:10] && input_thr_sel[9:8] == threshold_sel[3:2];
    endproperty
    a_grp_map: assert property (p_grp_map) else $error("group select misrouted");

    // Enabled inputs are driven during a pulse and nothing outside it
    property p_drive;
        @(posedge clk) disable iff (srst)
        cleaning_drive == (pulse_busy ? cleaning_enable_input : 24'h00_0000);
    endproperty
    a_drive: assert property (p_drive) else $error("drive not following pulse");
endmodule

`default_nettype wire

// >>> tb/sct_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the register port, one strobe per access
module sct_host_model (
    input wire logic clk,
    input wire sct_pkg::sct_rsp_s rsp,
    output var sct_pkg::sct_req_s req
);
    // Idle port until the first access
    initial req = '0;

    // Write strobe stands for exactly one sampling edge
    task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // Answer is registered, so it is sampled just after the taking edge
    task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h00_0000};
        @(posedge clk);
        req <= '0;
        #1;
        d = rsp.rdata;
    endtask
endmodule

`default_nettype wire

// >>> tb/test_sct_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sct_regs.svh"

// One comparison, counted; a miss is reported at once
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, x); end end

module test_sct_top;
    logic clk, srst, fire;
    logic [2:0] dur;
    logic [3:0] lvl;
    logic [23:0] d, e, r;
    int num_errors = 0, checks_done = 0, k, n;
    sct_pkg::sct_req_s req;
    sct_pkg::sct_rsp_s rsp;
    logic [23:0] en_o, drive_o, lvl_o;
    logic [11:0] thr_o;
    logic [47:0] ithr_o;

    sct_top sct_top_i (.clk(clk), .srst(srst), .req(req), .cleaning_pulse_duration(dur),
        .cleaning_current_level(lvl), .cleaning_pulse_fire(fire), .rsp(rsp),
        .cleaning_enable_input(en_o), .cleaning_drive(drive_o), .cleaning_level_15ma(lvl_o),
        .threshold_sel(thr_o), .input_thr_sel(ithr_o));
    sct_host_model sct_host_model_i (.clk(clk), .rsp(rsp), .req(req));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Each input takes the code of its group of four
    function automatic logic [47:0] exp_thr(input logic [11:0] t);
        for (int i = 0; i < 24; i++) exp_thr[2*i+:2] = t[2*(i/4)+:2];
    endfunction

    // Each input takes the level bit of its group of six
    function automatic logic [23:0] exp_lvl(input logic [3:0] l);
        for (int i = 0; i < 24; i++) exp_lvl[i] = l[i/6];
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Longest pulse is 25600 cycles, shortest 3200; the rest is under two hundred
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        fire = 1'b0;
        dur = 3'h0;
        lvl = 4'h0;
        void'($urandom(17325));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        sct_host_model_i.rd_reg(`SCT_OFF_CLEAN_EN, r);
        `CHK(r, 24'h00_0000)
        sct_host_model_i.rd_reg(`SCT_OFF_THRESH, r);
        `CHK(r, 24'h00_0000)
        `CHK(ithr_o, 48'h0000_0000_0000)
        // First four passes put one code in every group, then random words
        for (k = 0; k < 12; k++) begin
            d = (k < 4) ? {12'hFFF, {6{k[1:0]}}} : 24'($urandom);
            e = 24'($urandom);
            sct_host_model_i.wr_reg(`SCT_OFF_CLEAN_EN, e);
            sct_host_model_i.wr_reg(`SCT_OFF_THRESH, d);
            // Unmapped offset must neither store nor disturb the others
            sct_host_model_i.wr_reg(6'h05, ~e);
            sct_host_model_i.rd_reg(`SCT_OFF_CLEAN_EN, r);
            `CHK(r, e)
            // The answer strobe still stands in the cycle after the read
            `CHK(rsp.valid, 1'b1)
            sct_host_model_i.rd_reg(`SCT_OFF_THRESH, r);
            `CHK(r, d & 24'h00_0FFF)
            sct_host_model_i.rd_reg(6'h05, r);
            `CHK(r, 24'h00_0000)
            `CHK(en_o, e)
            `CHK(thr_o, d[11:0])
            `CHK(ithr_o, exp_thr(d[11:0]))
        end
        // Shortest and longest pulse; drive follows enables only inside it
        e = 24'($urandom) | 24'h80_0001;
        sct_host_model_i.wr_reg(`SCT_OFF_CLEAN_EN, e);
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            dur <= k ? 3'h7 : 3'h0;
            lvl <= 4'($urandom);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            n = (k * 7 + 1) * `SCT_PULSE_STEP_CYC;
            repeat (2) @(posedge clk);
            #1;
            `CHK(drive_o, e)
            `CHK(lvl_o, exp_lvl(lvl))
            repeat (n - 5) @(posedge clk);
            #1;
            `CHK(drive_o, e)
            // Last driven cycle is n - 1 edges after the fire was taken, off one edge later
            repeat (2) @(posedge clk);
            #1;
            `CHK(drive_o, e)
            @(posedge clk);
            #1;
            `CHK(drive_o, 24'h00_0000)
        end
        print_verdict();
    end
endmodule

`default_nettype wire
